//--- logic/cxs_consts.svh
// constants of the core support block: register map, field layout, reset values, timing
// assumes one 40 MHz core clock and an 8-bit special register space driven by the core
// Summary of operation
// - three-bit stretch field sits in the low bits of clock_control.
// - an external data move lasts two instruction cycles plus one per stretch unit.
// - stretch resets to one, giving three-cycle moves until firmware rewrites it.
// - stretch affects data-memory moves only, never program fetches.
// - stretch may be rewritten anytime; the next move uses the new value.
// - strobe is two clocks at stretch zero, else four clocks per stretch unit.
// - clock reference code 00/01/10 selects 12/24/48 MHz, resets to 00.
// - two 16-bit data pointers at 0x82/0x83 and 0x84/0x85.
// - pointer_select bit zero picks the pointer every pointer instruction uses.
// - the other seven pointer_select bits have no effect.
// - an increment of pointer_select toggles bit zero.
// - status word, accumulator and operand register are bit addressable; stack pointer not.
// - carry is set on carry out of bit seven, cleared by multiply and divide.
// - auxiliary carry marks a carry into or borrow from the upper nibble.
// - status bits five and one are user flags hardware never touches.
// - status bits four and three select register bank 0x00 to 0x18 base.
// - signed wrap flags add overflow, wide multiply product, divide by zero.
// - status bit zero always equals the parity of the accumulator.
// - one instruction cycle is four clocks.
`ifndef CXS_CONSTS_SVH
`define CXS_CONSTS_SVH
`define CXS_ADDR_SP         8'h81
`define CXS_ADDR_DATA_POINTER_ZERO_LOW       8'h82
`define CXS_ADDR_DATA_POINTER_ZERO_HIGH       8'h83
`define CXS_ADDR_DATA_POINTER_ONE_LOW       8'h84
`define CXS_ADDR_DATA_POINTER_ONE_HIGH       8'h85
`define CXS_ADDR_DPS        8'h86
`define CXS_ADDR_CKCTL      8'h8E
`define CXS_ADDR_PSW        8'hD0
`define CXS_ADDR_ACC        8'hE0
`define CXS_ADDR_B          8'hF0
`define CXS_RST_SP          8'h07
`define CXS_RST_STRETCH     3'h1
`define CXS_RST_CLK_REF     2'h0
`define CXS_CLK_REF_BAD     2'h3
`define CXS_STRETCH_W       3
`define CXS_PSW_CY          7
`define CXS_PSW_AC          6
`define CXS_PSW_F0          5
`define CXS_PSW_RS1         4
`define CXS_PSW_RS0         3
`define CXS_PSW_OV          2
`define CXS_PSW_F1          1
`define CXS_PSW_P           0
`define CXS_CLKS_PER_ICYC   5'h4
`define CXS_STROBE_ZERO     5'h2
`define CXS_HOLD_ZERO       5'h2
`define CXS_HOLD_STRETCH    5'h4
`define CXS_CORE_CLK_NS     25
`endif

//--- logic/cxs_pkg.sv
// types shared by the core support block
// assumes cxs_consts.svh supplies all numeric constants
package cxs_pkg;
  typedef enum logic [2:0] {
    CXS_OP_NONE = 3'h0,
    CXS_OP_ADD  = 3'h1,
    CXS_OP_SUBB = 3'h2,
    CXS_OP_MUL  = 3'h3,
    CXS_OP_DIV  = 3'h4,
    CXS_OP_CMP  = 3'h5
  } cxs_alu_op_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       inc;
    logic [7:0] wdata;
  } cxs_sfr_req_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       val;
  } cxs_bit_req_type;

  typedef struct packed {
    cxs_alu_op_type op;
    logic [7:0]     a;
    logic [7:0]     b;
    logic           cin;
  } cxs_flag_req_type;

  typedef struct packed {
    logic       start;
    logic       write;
    logic [7:0] wdata;
  } cxs_xmove_req_type;

  typedef enum logic [1:0] {
    CXS_XS_IDLE   = 2'h0,
    CXS_XS_SETUP  = 2'h1,
    CXS_XS_STROBE = 2'h3,
    CXS_XS_HOLD   = 2'h2
  } cxs_xstate_type;
endpackage

//--- logic/cxs_xmove_strobe.sv
// external data move sequencer: setup, stretched strobe, hold
// assumes start is a one-cycle pulse from the core and pins are synchronous to core_clk_i
`timescale 1ns/1ps
`include "cxs_consts.svh"
module cxs_xmove_strobe #(
  parameter int STRETCH_W = `CXS_STRETCH_W
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // request
  input  wire logic                  start_i,
  input  wire logic                  write_i,
  input  wire logic [15:0]           addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic [STRETCH_W-1:0]  stretch_i,
  // status
  output logic                       busy_o,
  output logic                       done_o,
  output logic [7:0]                 rdata_o,
  // memory pins
  output logic [15:0]                addr_o,
  output logic                       rd_n_o,
  output logic                       wr_n_o,
  output logic [7:0]                 data_o,
  output logic                       data_oe_o,
  input  wire logic [7:0]            data_i
);
  import cxs_pkg::*;

  cxs_xstate_type  state_r;
  logic [4:0]      cnt_r;
  logic            write_r;
  logic [4:0]      strobe_len_r;
  logic [4:0]      hold_len_r;

  // stretch is caught at start so a rewrite mid-move only affects the next one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r      <= CXS_XS_IDLE;
      cnt_r        <= 5'h00;
      write_r      <= 1'b0;
      strobe_len_r <= `CXS_STROBE_ZERO;
      hold_len_r   <= `CXS_HOLD_ZERO;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      rd_n_o       <= 1'b1;
      wr_n_o       <= 1'b1;
      data_oe_o    <= 1'b0;
      addr_o       <= 16'h0000;
      data_o       <= 8'h00;
      rdata_o      <= 8'h00;
    end else begin
      done_o <= 1'b0;
      unique case (state_r)
        CXS_XS_IDLE: if (start_i) begin
          state_r      <= CXS_XS_SETUP;
          cnt_r        <= `CXS_CLKS_PER_ICYC - 5'h1;
          write_r      <= write_i;
          addr_o       <= addr_i;
          data_o       <= wdata_i;
          data_oe_o    <= write_i;
          busy_o       <= 1'b1;
          strobe_len_r <= (stretch_i == '0) ? `CXS_STROBE_ZERO
                                            : {stretch_i, 2'b00};
          hold_len_r   <= (stretch_i == '0) ? `CXS_HOLD_ZERO : `CXS_HOLD_STRETCH;
        end
        CXS_XS_SETUP: if (cnt_r == 5'h00) begin
          state_r <= CXS_XS_STROBE;
          cnt_r   <= strobe_len_r - 5'h1;
          rd_n_o  <= write_r;
          wr_n_o  <= ~write_r;
        end else begin
          cnt_r <= cnt_r - 5'h1;
        end
        CXS_XS_STROBE: if (cnt_r == 5'h00) begin
          state_r <= CXS_XS_HOLD;
          cnt_r   <= hold_len_r - 5'h1;
          rd_n_o  <= 1'b1;
          wr_n_o  <= 1'b1;
          if (!write_r) rdata_o <= data_i;
        end else begin
          cnt_r <= cnt_r - 5'h1;
        end
        CXS_XS_HOLD: if (cnt_r == 5'h00) begin
          state_r   <= CXS_XS_IDLE;
          busy_o    <= 1'b0;
          done_o    <= 1'b1;
          data_oe_o <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 5'h1;
        end
      endcase
    end
  end
endmodule // cxs_xmove_strobe

//--- logic/cxs_core_regs.sv
// core support registers: stack pointer, dual data pointers, status word,
// accumulator, operand register, clock control and the stretched external move
// assumes the core presents register, bit and flag requests synchronous to core_clk_i
`timescale 1ns/1ps
`include "cxs_consts.svh"
module cxs_core_regs #(
  parameter int STRETCH_W = `CXS_STRETCH_W
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // byte access to the special registers
  input  wire cxs_pkg::cxs_sfr_req_type  sfr_req_i,
  output logic [7:0]                     sfr_rdata_o,
  // bit access
  input  wire cxs_pkg::cxs_bit_req_type  bit_req_i,
  output logic                           bit_rdata_o,
  // arithmetic flag update
  input  wire cxs_pkg::cxs_flag_req_type flag_req_i,
  // datapath write-back
  input  wire logic                      acc_we_i,
  input  wire logic [7:0]                acc_wdata_i,
  input  wire logic                      b_we_i,
  input  wire logic [7:0]                b_wdata_i,
  input  wire logic                      dptr_inc_i,
  // core clock reference
  input  wire logic                      clk_ref_we_i,
  input  wire logic [1:0]                clk_ref_i,
  output logic [1:0]                     clk_ref_sel_o,
  // external data move
  input  wire cxs_pkg::cxs_xmove_req_type xmove_req_i,
  output logic                           xmove_busy_o,
  output logic                           xmove_done_o,
  output logic [7:0]                     xmove_rdata_o,
  // external memory pins
  output logic [15:0]                    xmem_addr_o,
  output logic                           xmem_rd_n_o,
  output logic                           xmem_wr_n_o,
  output logic [7:0]                     xmem_data_o,
  output logic                           xmem_data_oe_o,
  input  wire logic [7:0]                xmem_data_i,
  // state views
  output logic [7:0]                     psw_o,
  output logic [7:0]                     acc_o,
  output logic [7:0]                     b_o,
  output logic [7:0]                     sp_o,
  output logic [15:0]                    dptr_o,
  output logic [4:0]                     bank_base_o,
  output logic [STRETCH_W-1:0]           stretch_o
);
  import cxs_pkg::*;

  logic [7:0]            sp_r;
  logic [7:0]            sp_nxt;
  logic [7:0]            psw_r;
  logic [7:0]            psw_nxt;
  logic [7:0]            acc_r;
  logic [7:0]            acc_nxt;
  logic [7:0]            b_r;
  logic [7:0]            b_nxt;
  logic                  dps_r;
  logic                  dps_nxt;
  logic [STRETCH_W-1:0]  stretch_r;
  logic [1:0]            clk_ref_r;
  logic [15:0]           dptr_r [2];
  logic [15:0]           dptr_nxt [2];
  logic [15:0]           dptr_act_r;
  logic [7:0]            bit_byte;
  logic                  cy_upd;
  logic                  cy_new;
  logic                  ac_upd;
  logic                  ac_new;
  logic                  ov_upd;
  logic                  ov_new;
  logic [8:0]            sum9;
  logic [4:0]            nib5;
  logic [15:0]           prod16;

  // decode helpers
  function automatic logic sfr_wr_hit(input logic [7:0] addr);
    return sfr_req_i.wr && (sfr_req_i.addr == addr);
  endfunction

  function automatic logic bitable(input logic [7:0] base);
    return (base == `CXS_ADDR_PSW) || (base == `CXS_ADDR_ACC) ||
           (base == `CXS_ADDR_B);
  endfunction

  function automatic logic bit_wr_hit(input logic [7:0] base);
    return bit_req_i.wr && (bit_req_i.addr[7:3] == base[7:3]) && bitable(base);
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] old,
                                         input logic [2:0] pos,
                                         input logic       val);
    logic [7:0] res;
    res      = old;
    res[pos] = val;
    return res;
  endfunction

  function automatic logic [7:0] reg_view(input logic [7:0] addr);
    logic [7:0] res;
    res = 8'h00;
    case (addr)
      `CXS_ADDR_SP:    res = sp_r;
      `CXS_ADDR_DATA_POINTER_ZERO_LOW:  res = dptr_r[0][7:0];
      `CXS_ADDR_DATA_POINTER_ZERO_HIGH:  res = dptr_r[0][15:8];
      `CXS_ADDR_DATA_POINTER_ONE_LOW:  res = dptr_r[1][7:0];
      `CXS_ADDR_DATA_POINTER_ONE_HIGH:  res = dptr_r[1][15:8];
      `CXS_ADDR_DPS:   res = {7'h00, dps_r};
      `CXS_ADDR_CKCTL: res = {{(8-STRETCH_W){1'b0}}, stretch_r};
      `CXS_ADDR_PSW:   res = psw_r;
      `CXS_ADDR_ACC:   res = acc_r;
      `CXS_ADDR_B:     res = b_r;
      default:         res = 8'h00;
    endcase
    return res;
  endfunction

  // flag results of the current arithmetic step
  always_comb begin
    cy_upd = 1'b0;
    cy_new = 1'b0;
    ac_upd = 1'b0;
    ac_new = 1'b0;
    ov_upd = 1'b0;
    ov_new = 1'b0;
    sum9   = 9'h000;
    nib5   = 5'h00;
    prod16 = 16'h0000;
    unique case (flag_req_i.op)
      CXS_OP_NONE: begin
        cy_upd = 1'b0;
      end
      CXS_OP_ADD: begin
        sum9   = {1'b0, flag_req_i.a} + {1'b0, flag_req_i.b} + {8'h00, flag_req_i.cin};
        nib5   = {1'b0, flag_req_i.a[3:0]} + {1'b0, flag_req_i.b[3:0]}
               + {4'h0, flag_req_i.cin};
        cy_upd = 1'b1;
        cy_new = sum9[8];
        ac_upd = 1'b1;
        ac_new = nib5[4];
        ov_upd = 1'b1;
        ov_new = (flag_req_i.a[7] == flag_req_i.b[7]) &&
                 (sum9[7] != flag_req_i.a[7]);
      end
      CXS_OP_SUBB: begin
        sum9   = {1'b0, flag_req_i.a} - {1'b0, flag_req_i.b} - {8'h00, flag_req_i.cin};
        nib5   = {1'b0, flag_req_i.a[3:0]} - {1'b0, flag_req_i.b[3:0]}
               - {4'h0, flag_req_i.cin};
        cy_upd = 1'b1;
        cy_new = sum9[8];
        ac_upd = 1'b1;
        ac_new = nib5[4];
        ov_upd = 1'b1;
        ov_new = (flag_req_i.a[7] != flag_req_i.b[7]) &&
                 (sum9[7] != flag_req_i.a[7]);
      end
      CXS_OP_MUL: begin
        prod16 = {8'h00, flag_req_i.a} * {8'h00, flag_req_i.b};
        cy_upd = 1'b1;
        cy_new = 1'b0;
        ov_upd = 1'b1;
        ov_new = (prod16[15:8] != 8'h00);
      end
      CXS_OP_DIV: begin
        cy_upd = 1'b1;
        cy_new = 1'b0;
        ov_upd = 1'b1;
        ov_new = (flag_req_i.b == 8'h00);
      end
      CXS_OP_CMP: begin
        cy_upd = 1'b1;
        cy_new = (flag_req_i.a < flag_req_i.b);
      end
      default: begin
        cy_upd = 1'b0;
      end
    endcase
  end

  // accumulator: datapath, then bit write, then byte write
  always_comb begin
    acc_nxt = acc_r;
    if (acc_we_i) acc_nxt = acc_wdata_i;
    if (bit_wr_hit(`CXS_ADDR_ACC)) acc_nxt = put_bit(acc_nxt, bit_req_i.addr[2:0],
                                                     bit_req_i.val);
    if (sfr_wr_hit(`CXS_ADDR_ACC)) acc_nxt = sfr_req_i.wdata;
  end

  always_comb begin
    b_nxt = b_r;
    if (b_we_i) b_nxt = b_wdata_i;
    if (bit_wr_hit(`CXS_ADDR_B)) b_nxt = put_bit(b_nxt, bit_req_i.addr[2:0],
                                                 bit_req_i.val);
    if (sfr_wr_hit(`CXS_ADDR_B)) b_nxt = sfr_req_i.wdata;
  end

  // stack pointer takes byte writes only; bit writes never reach it
  always_comb begin
    sp_nxt = sp_r;
    if (sfr_wr_hit(`CXS_ADDR_SP)) sp_nxt = sfr_req_i.wdata;
  end

  // status word: software first, arithmetic flags override in the same cycle
  always_comb begin
    psw_nxt = psw_r;
    if (bit_wr_hit(`CXS_ADDR_PSW)) psw_nxt = put_bit(psw_nxt, bit_req_i.addr[2:0],
                                                     bit_req_i.val);
    if (sfr_wr_hit(`CXS_ADDR_PSW)) psw_nxt = sfr_req_i.wdata;
    if (cy_upd) psw_nxt[`CXS_PSW_CY] = cy_new;
    if (ac_upd) psw_nxt[`CXS_PSW_AC] = ac_new;
    if (ov_upd) psw_nxt[`CXS_PSW_OV] = ov_new;
    // parity is not storable: it follows the accumulator it will sit beside
    psw_nxt[`CXS_PSW_P] = ^acc_nxt;
  end

  // pointer select: only bit zero lives, an increment flips it
  always_comb begin
    dps_nxt = dps_r;
    if (sfr_req_i.inc && (sfr_req_i.addr == `CXS_ADDR_DPS)) dps_nxt = ~dps_r;
    if (sfr_wr_hit(`CXS_ADDR_DPS)) dps_nxt = sfr_req_i.wdata[0];
  end

  // two data pointers, byte-writable, the selected one incrementable
  for (genvar gi = 0; gi < 2; gi++) begin : g_dptr
    localparam logic [7:0] LO_ADDR = `CXS_ADDR_DATA_POINTER_ZERO_LOW + 8'(2 * gi);
    localparam logic       SEL_VAL = 1'(gi);

    always_comb begin
      dptr_nxt[gi] = dptr_r[gi];
      if (dptr_inc_i && (dps_r == SEL_VAL)) dptr_nxt[gi] = dptr_r[gi] + 16'h0001;
      if (sfr_wr_hit(LO_ADDR)) dptr_nxt[gi][7:0] = sfr_req_i.wdata;
      if (sfr_wr_hit(LO_ADDR + 8'h01)) dptr_nxt[gi][15:8] = sfr_req_i.wdata;
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        dptr_r[gi] <= 16'h0000;
      end else begin
        dptr_r[gi] <= dptr_nxt[gi];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc_r <= 8'h00;
      b_r   <= 8'h00;
      sp_r  <= `CXS_RST_SP;
    end else begin
      acc_r <= acc_nxt;
      b_r   <= b_nxt;
      sp_r  <= sp_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      psw_r <= 8'h00;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dps_r      <= 1'b0;
      dptr_act_r <= 16'h0000;
    end else begin
      dps_r      <= dps_nxt;
      dptr_act_r <= dps_nxt ? dptr_nxt[1] : dptr_nxt[0];
    end
  end

  // stretch field: low bits of clock_control, upper bits not stored
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stretch_r <= STRETCH_W'(`CXS_RST_STRETCH);
    end else if (sfr_wr_hit(`CXS_ADDR_CKCTL)) begin
      stretch_r <= sfr_req_i.wdata[STRETCH_W-1:0];
    end
  end

  // clock reference: the unused code is refused so the core never loses its clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clk_ref_r <= `CXS_RST_CLK_REF;
    end else if (clk_ref_we_i && (clk_ref_i != `CXS_CLK_REF_BAD)) begin
      clk_ref_r <= clk_ref_i;
    end
  end

  // read paths: one cycle behind the request
  always_comb begin
    bit_byte = bitable({bit_req_i.addr[7:3], 3'b000}) ?
               reg_view({bit_req_i.addr[7:3], 3'b000}) : 8'h00;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
      bit_rdata_o <= 1'b0;
    end else begin
      if (sfr_req_i.rd) sfr_rdata_o <= reg_view(sfr_req_i.addr);
      bit_rdata_o <= bit_byte[bit_req_i.addr[2:0]];
    end
  end

  // only data moves see the stretch; the fetch path has no connection to it
  cxs_xmove_strobe #(
    .STRETCH_W (STRETCH_W)
  ) u_xmove (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (xmove_req_i.start),
    .write_i    (xmove_req_i.write),
    .addr_i     (dptr_act_r),
    .wdata_i    (xmove_req_i.wdata),
    .stretch_i  (stretch_r),
    .busy_o     (xmove_busy_o),
    .done_o     (xmove_done_o),
    .rdata_o    (xmove_rdata_o),
    .addr_o     (xmem_addr_o),
    .rd_n_o     (xmem_rd_n_o),
    .wr_n_o     (xmem_wr_n_o),
    .data_o     (xmem_data_o),
    .data_oe_o  (xmem_data_oe_o),
    .data_i     (xmem_data_i)
  );

  // views straight off the flops
  assign psw_o         = psw_r;
  assign acc_o         = acc_r;
  assign b_o           = b_r;
  assign sp_o          = sp_r;
  assign dptr_o        = dptr_act_r;
  assign bank_base_o   = {psw_r[`CXS_PSW_RS1:`CXS_PSW_RS0], 3'b000};
  assign stretch_o     = stretch_r;
  assign clk_ref_sel_o = clk_ref_r;
endmodule // cxs_core_regs

//--- dv/cxs_core_regs_sva.sv
// checker on the core support block ports, bound into cxs_core_regs
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module cxs_core_regs_sva
  import cxs_pkg::*;
#(
  parameter int STRETCH_W = 3
) (
  // clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  // requests
  input wire cxs_pkg::cxs_sfr_req_type   sfr_req_i,
  input wire cxs_pkg::cxs_xmove_req_type xmove_req_i,
  // outputs
  input wire logic [7:0]                 psw_o,
  input wire logic [7:0]                 acc_o,
  input wire logic [4:0]                 bank_base_o,
  input wire logic [STRETCH_W-1:0]       stretch_o,
  input wire logic                       xmove_busy_o,
  input wire logic                       xmove_done_o,
  input wire logic                       xmem_rd_n_o,
  input wire logic                       xmem_wr_n_o
);
  logic                 strb;
  logic                 ck_wr;
  logic [STRETCH_W-1:0] st_wd;
  logic [STRETCH_W-1:0] st_r;
  logic [5:0]           lo_r;
  logic [5:0]           bz_r;
  logic [5:0]           lo_exp;
  logic [5:0]           bz_exp;
  assign strb   = !(xmem_rd_n_o && xmem_wr_n_o);
  assign ck_wr  = sfr_req_i.wr && (sfr_req_i.addr == 8'h8E);
  assign st_wd  = sfr_req_i.wdata[STRETCH_W-1:0];
  assign lo_exp = (st_r == '0) ? 6'h02 : 6'(st_r) << 2;
  assign bz_exp = (6'(st_r) << 2) + 6'h08;
  // stretch latched at an accepted start, since firmware may rewrite it mid-move
  always_ff @(posedge core_clk_i) begin
    if (rst_i) st_r <= '0;
    else if (xmove_req_i.start && !xmove_busy_o) st_r <= stretch_o;
  end
  always_ff @(posedge core_clk_i) lo_r <= strb ? lo_r + 6'h01 : 6'h00;
  always_ff @(posedge core_clk_i) bz_r <= xmove_busy_o ? bz_r + 6'h01 : 6'h00;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_setup;
    (xmove_busy_o && !strb) [*4];
  endsequence
  sequence s_strobe;
    xmove_busy_o && strb;
  endsequence
  property p_move;
    xmove_req_i.start && !xmove_busy_o |=> s_setup ##1 s_strobe;
  endproperty
  a_parity_acc: assert property (psw_o[0] == ^acc_o)
    else $error("parity bit differs from accumulator");
  a_bank_base: assert property (bank_base_o == {psw_o[4:3], 3'h0})
    else $error("bank base off");
  a_stretch_reset: assert property ($fell(rst_i) |-> stretch_o == 3'h1)
    else $error("stretch not one after reset");
  a_stretch_write: assert property (ck_wr |=> stretch_o == $past(st_wd))
    else $error("stretch missed a write");
  a_setup_first: assert property (p_move)
    else $error("setup length wrong");
  a_strobe_width: assert property ($fell(strb) |-> lo_r == lo_exp)
    else $error("strobe width wrong");
  a_busy_length: assert property ($fell(xmove_busy_o) |-> bz_r == bz_exp)
    else $error("move length wrong");
  a_done_pulse: assert property ($fell(xmove_busy_o) |-> xmove_done_o ##1 !xmove_done_o)
    else $error("done pulse wrong");
endmodule // cxs_core_regs_sva

bind cxs_core_regs cxs_core_regs_sva #(.STRETCH_W(STRETCH_W)) u_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i), .xmove_req_i(xmove_req_i),
  .psw_o(psw_o), .acc_o(acc_o), .bank_base_o(bank_base_o), .stretch_o(stretch_o),
  .xmove_busy_o(xmove_busy_o), .xmove_done_o(xmove_done_o), .xmem_rd_n_o(xmem_rd_n_o),
  .xmem_wr_n_o(xmem_wr_n_o)
);

//--- dv/cxs_xmem_model.sv
// slow data memory on the external move pins
// assumes registered pins; read data valid lat_i clocks into the strobe
`timescale 1ns/1ps
module cxs_xmem_model (
  // clock
  input  wire logic        core_clk_i,
  // pins
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        data_oe_i,
  input  wire logic [4:0]  lat_i,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:255];
  logic [4:0] cnt_r;
  logic [7:0] junk_r;
  always_ff @(posedge core_clk_i) cnt_r <= rd_n_i ? 5'h00 : cnt_r + 5'h01;
  // bus toggles when not answering so a stale value never passes
  always_ff @(posedge core_clk_i) junk_r <= (junk_r === 8'hA5) ? 8'h5A : 8'hA5;
  always_ff @(posedge core_clk_i) if (!wr_n_i && data_oe_i) mem[addr_i[7:0]] <= data_i;
  assign data_o = (!rd_n_i && cnt_r >= lat_i) ? mem[addr_i[7:0]] : junk_r;
endmodule // cxs_xmem_model

//--- dv/test_cxs_core_regs.sv
// self-checking bench for cxs_core_regs with a slow data memory model
// assumes package, design, memory model and checker compiled first
`timescale 1ns/1ps
module test_cxs_core_regs;
  import cxs_pkg::*;
  logic              core_clk_i;
  logic              rst_i;
  cxs_sfr_req_type   sreq;
  cxs_bit_req_type   breq;
  cxs_flag_req_type  freq;
  cxs_xmove_req_type xreq;
  logic              acc_we, dinc, crwe, busy, done, rd_n, wr_n, xoe, bq;
  logic [1:0]        cr, crsel;
  logic [2:0]        stretch;
  logic [4:0]        lat, bank;
  logic [7:0]        acc_wd, rdata, xrd, xdo, xdi, program_status_word, acc, sp, q;
  logic [15:0]       xaddr, dptr;
  int                errors, comparisons, bc, sw, i;
  cxs_core_regs u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sreq), .sfr_rdata_o(rdata),
    .bit_req_i(breq), .bit_rdata_o(bq), .flag_req_i(freq), .acc_we_i(acc_we),
    .acc_wdata_i(acc_wd), .b_we_i(1'b0), .b_wdata_i(8'h00), .dptr_inc_i(dinc),
    .clk_ref_we_i(crwe), .clk_ref_i(cr), .clk_ref_sel_o(crsel), .xmove_req_i(xreq),
    .xmove_busy_o(busy), .xmove_done_o(done), .xmove_rdata_o(xrd), .xmem_addr_o(xaddr),
    .xmem_rd_n_o(rd_n), .xmem_wr_n_o(wr_n), .xmem_data_o(xdo), .xmem_data_oe_o(xoe),
    .xmem_data_i(xdi), .psw_o(program_status_word), .acc_o(acc), .b_o(), .sp_o(sp), .dptr_o(dptr),
    .bank_base_o(bank), .stretch_o(stretch)
  );
  cxs_xmem_model u_mem (
    .core_clk_i(core_clk_i), .addr_i(xaddr), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(xdo), .data_oe_i(xoe), .lat_i(lat), .data_o(xdi)
  );
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // c: write, read, increment
  task automatic sfr(input logic [7:0] a, input logic [2:0] c, input logic [7:0] d);
    sreq <= {a, c, d};
    @(posedge core_clk_i);
    sreq <= '0;
    @(posedge core_clk_i);
    q = rdata;
  endtask
  task automatic bitw(input logic [7:0] a, input logic v);
    breq <= {a, 1'b1, v};
    @(posedge core_clk_i);
    breq <= {a, 2'h0};
    repeat (2) @(posedge core_clk_i);
    chk("bit read", 16'(v), 16'(bq));
  endtask
  task automatic flg(input cxs_alu_op_type o, input logic [7:0] a, b, m, e);
    freq <= {o, a, b, 1'b0};
    @(posedge core_clk_i);
    freq <= '0;
    @(posedge core_clk_i);
    chk("psw flags", {8'h00, e}, {8'h00, program_status_word & m});
  endtask
  task automatic mv(input logic w, input logic [7:0] d, input logic [2:0] s);
    bc = 0;
    sw = 0;
    sfr(8'h8E, 3'b100, {5'h00, s});
    lat <= s[0] ? 5'({s, 2'b00}) - 5'h01 : 5'h00;
    xreq <= {1'b1, w, d};
    @(posedge core_clk_i);
    xreq <= '0;
    for (i = 0; i < 60 && done !== 1'b1; i++) begin
      @(posedge core_clk_i);
      bc += (busy === 1'b1);
      sw += (rd_n === 1'b0 || wr_n === 1'b0);
    end
    if (i == 60) begin
      chk("move done", 16'h1, 16'h0);
      report_and_stop();
    end
    chk("busy clocks", 16'(4 * (2 + s)), 16'(bc));
    chk("strobe clocks", (s == 3'h0) ? 16'h2 : 16'(4 * s), 16'(sw));
    if (!w) chk("move read", {8'h00, d}, {8'h00, xrd});
  endtask
  task automatic t_ctrl();
    chk("stretch", 16'h1, 16'(stretch));
    chk("stack pointer", 16'h07, 16'(sp));
    sfr(8'h8E, 3'b010, 8'h00);
    chk("clock_control", 16'h01, 16'(q));
    sfr(8'h8E, 3'b100, 8'hFF);
    sfr(8'h8E, 3'b010, 8'h00);
    chk("clock_control", 16'h07, 16'(q));
    sfr(8'h87, 3'b100, 8'h55);
    sfr(8'h87, 3'b010, 8'h00);
    chk("unmapped", 16'h00, 16'(q));
    chk("clock ref", 16'h0, 16'(crsel));
    for (int c = 1; c < 4; c++) begin
      crwe <= 1'b1;
      cr <= 2'(c);
      @(posedge core_clk_i);
      crwe <= 1'b0;
      @(posedge core_clk_i);
      chk("clock ref", (c == 3) ? 16'h2 : 16'(c), 16'(crsel));
    end
  endtask
  task automatic t_dptr();
    sfr(8'h86, 3'b010, 8'h00);
    chk("pointer_select", 16'h00, 16'(q));
    sfr(8'h82, 3'b100, 8'h11);
    sfr(8'h83, 3'b100, 8'h22);
    sfr(8'h84, 3'b100, 8'h33);
    sfr(8'h85, 3'b100, 8'h44);
    sfr(8'h86, 3'b100, 8'hFE);
    chk("dptr", 16'h2211, dptr);
    sfr(8'h86, 3'b100, 8'hFF);
    chk("dptr", 16'h4433, dptr);
    sfr(8'h86, 3'b010, 8'h00);
    chk("pointer_select", 16'h01, 16'(q));
    sfr(8'h86, 3'b001, 8'h00);
    chk("dptr", 16'h2211, dptr);
    dinc <= 1'b1;
    @(posedge core_clk_i);
    dinc <= 1'b0;
    sfr(8'h82, 3'b010, 8'h00);
    chk("data_pointer_zero_low", 16'h12, 16'(q));
  endtask
  task automatic t_flags();
    flg(CXS_OP_ADD, 8'h7F, 8'h01, 8'hC4, 8'h44);
    flg(CXS_OP_ADD, 8'hFF, 8'h01, 8'hC4, 8'hC0);
    flg(CXS_OP_MUL, 8'h10, 8'h10, 8'h84, 8'h04);
    flg(CXS_OP_SUBB, 8'h10, 8'h01, 8'hC4, 8'h40);
    flg(CXS_OP_DIV, 8'h05, 8'h00, 8'h84, 8'h04);
    flg(CXS_OP_CMP, 8'h01, 8'h02, 8'h80, 8'h80);
  endtask
  task automatic t_psw();
    sfr(8'hD0, 3'b100, 8'h22);
    bitw(8'hD3, 1'b1);
    bitw(8'hD4, 1'b1);
    chk("psw", 16'h3A, 16'(program_status_word));
    chk("bank base", 16'h18, 16'(bank));
    acc_we <= 1'b1;
    acc_wd <= 8'h07;
    @(posedge core_clk_i);
    acc_we <= 1'b0;
    bitw(8'hE3, 1'b1);
    chk("acc", 16'h0F, 16'(acc));
    chk("psw", 16'h3A, 16'(program_status_word));
    bitw(8'h81, 1'b0);
    chk("stack pointer", 16'h07, 16'(sp));
  endtask
  task automatic t_move();
    for (int s = 0; s < 8; s++) begin
      mv(1'b1, 8'(8'h5A + s * 19), 3'(s));
      mv(1'b0, 8'(8'h5A + s * 19), 3'(s));
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {sreq, breq, freq, xreq, acc_we, dinc, crwe, cr, lat, acc_wd} = '0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_ctrl();
    t_dptr();
    t_flags();
    t_psw();
    t_move();
    report_and_stop();
  end
endmodule // test_cxs_core_regs
